// ---- hw/sta_aux_bank.sv ----
// Side-info register bank of the transmitter with APB access
`timescale 1ns/1ps
`include "sta_defines.svh"
module sta_aux_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire sta_pkg::sta_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame timing from the encoder
  input wire logic frame_adv,
  input wire logic block_start,
  // Bits decoded by the receiver
  input wire logic [7:0] rx_aux_bits,
  // Bits to the encoder
  output logic [7:0] tx_aux_bits,
  output logic side_info_origin_select
);
  import sta_pkg::*;

  sta_state_s s_r;
  sta_state_s s_nxt;

  logic [15:0] widx;
  logic aligned;
  logic hit_bank;
  logic hit_sel;
  logic hit_pos;
  logic [2:0] bsel;
  logic [6:0] flat;
  logic acc_first;
  logic acc_done;
  logic [7:0] lane_bits;
  logic lane_load;
  logic [15:0] wr_word;
  logic first_cs_bit;

  // Address decode
  always_comb begin
    widx = paddr[`STA_ADDR_W-1:2];
    aligned = (paddr[1:0] == 2'h0);
    hit_sel = aligned && (widx == `STA_SEL_IDX);
    hit_pos = aligned && (widx == `STA_POS_IDX);
    hit_bank = aligned && (widx >= `STA_CS_L_IDX) &&
      (widx <= `STA_LAST_IDX) && ({3'h0, widx[3:0]} < `STA_WORDS);
    bsel = 3'((widx - `STA_CS_L_IDX) >> `STA_STRIDE_SH);
    flat = 7'(bsel * `STA_WORDS) + {3'h0, widx[3:0]};
  end

  // One wait state, then the transfer completes
  assign acc_first = psel && penable && !s_r.pready;
  assign acc_done = psel && penable && s_r.pready;
  assign wr_word = pwdata[15:0];
  assign lane_load = frame_adv && block_start;
  assign first_cs_bit = s_r.bank[0][0];

  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (acc_first) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !(hit_bank || hit_sel || hit_pos);
      s_nxt.prdata = 32'h0;
      if (!pwrite) begin
        if (hit_bank) begin
          s_nxt.prdata = {16'h0, s_r.bank[flat]};
        end else if (hit_sel) begin
          s_nxt.prdata = {31'h0, s_r.sel};
        end else if (hit_pos) begin
          s_nxt.prdata = {23'h0, s_r.sel, s_r.idx};
        end
      end
    end
    if (acc_done && pwrite) begin
      if (hit_bank) begin
        s_nxt.bank[flat] = wr_word;
      end else if (hit_sel) begin
        s_nxt.sel = pwdata[`STA_SEL_BIT];
      end
    end
    if (frame_adv) begin
      // Register banks or receiver copy
      if (s_r.sel) begin
        s_nxt.aux = rx_aux_bits;
      end else begin
        s_nxt.aux = lane_bits;
      end
      // Frame position within the block
      if (block_start) begin
        s_nxt.idx = 8'h01;
      end else if (s_r.idx == `STA_LAST_BIT) begin
        s_nxt.idx = `STA_IDX_RST;
      end else begin
        s_nxt.idx = s_r.idx + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r.bank <= '0;
      s_r.sel <= `STA_SEL_RST;
      s_r.idx <= `STA_IDX_RST;
      s_r.aux <= 8'h00;
      s_r.prdata <= 32'h0;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // One lane per bank; word x supplies stream bits 16x to 16x+15
  genvar b;
  generate
    for (b = 0; b < `STA_BANKS; b = b + 1) begin : g_lane
      sta_lane_if lif ();
      assign lif.load = lane_load;
      assign lif.image = s_r.bank[b * `STA_WORDS +: 12];
      assign lif.idx = s_r.idx;
      assign lane_bits[b] = lif.bit_o;
      sta_lane u_lane (
        .sys_clk(sys_clk),
        .rst(rst),
        .lif(lif)
      );
    end
  endgenerate

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign tx_aux_bits = s_r.aux;
  assign side_info_origin_select = s_r.sel;

  // Checks
  bank_reset_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (s_r.bank == '0) && (s_r.sel == 1'b0))
    else $error("banks or select not zero after reset");

  wr_store_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank |=>
      s_r.bank[$past(flat)] == $past(wr_word))
    else $error("bank write not stored");

  rd_return_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first && !pwrite && hit_bank |=>
      pready && !pslverr && (prdata[31:16] == 16'h0) &&
      (prdata[15:0] == s_r.bank[$past(flat)]))
    else $error("bank read returned wrong word");

  ready_pulse_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first |=> pready ##1 !pready)
    else $error("pready not a single cycle answer");

  unmapped_err_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first && !(hit_bank || hit_sel || hit_pos) |=>
      pready && pslverr && (prdata == 32'h0))
    else $error("unmapped access not refused");

  bank_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(acc_done && pwrite) |=> $stable(s_r.bank))
    else $error("bank changed without a write");

  gap_word_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first && aligned && (widx == `STA_PB_R_IDX + 16'h000C) |=>
      pslverr)
    else $error("word after a bank accepted");

  sel_gate_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    frame_adv && !s_r.sel |=> tx_aux_bits == $past(lane_bits))
    else $error("banked bits not sent with select at zero");

  rx_copy_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    frame_adv && s_r.sel |=> tx_aux_bits == $past(rx_aux_bits))
    else $error("receiver bits not copied with select at one");

  first_bit_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    lane_load && !s_r.sel |=> tx_aux_bits[0] == $past(first_cs_bit))
    else $error("block did not start with bit 0 of word 0");

  idx_restart_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    lane_load |=> s_r.idx == 8'h01)
    else $error("frame position not restarted");

  idx_step_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    frame_adv && !block_start && (s_r.idx < `STA_LAST_BIT) |=>
      s_r.idx == $past(s_r.idx) + 8'h01)
    else $error("frame position did not step");

  aux_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !frame_adv |=> $stable(tx_aux_bits) && $stable(s_r.idx))
    else $error("bits moved without a frame");

  // Per-bank landing, decoded from the index, not from flat
  cs_left_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_CS_L_IDX)
      |=> s_r.bank[7'h00 + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("left status word not stored");

  cs_right_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_CS_R_IDX)
      |=> s_r.bank[7'h0C + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("right status word not stored");

  user_left_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_UD_L_IDX)
      |=> s_r.bank[7'h18 + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("left user word not stored");

  user_right_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_UD_R_IDX)
      |=> s_r.bank[7'h24 + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("right user word not stored");

  valid_left_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_VB_L_IDX)
      |=> s_r.bank[7'h30 + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("left validity word not stored");

  valid_right_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_VB_R_IDX)
      |=> s_r.bank[7'h3C + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("right validity word not stored");

  parity_left_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_PB_L_IDX)
      |=> s_r.bank[7'h48 + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("left parity word not stored");

  parity_right_wr_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank && ((widx & 16'hFFF0) == `STA_PB_R_IDX)
      |=> s_r.bank[7'h54 + {3'h0, $past(widx[3:0])}] == $past(wr_word))
    else $error("right parity word not stored");

  // Select, position and refusal
  sel_store_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_sel |=>
      side_info_origin_select == $past(pwdata[`STA_SEL_BIT]))
    else $error("origin select not stored");

  sel_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first && !pwrite && hit_sel |=>
      prdata == {31'h0, $past(s_r.sel)})
    else $error("origin select read back wrong");

  pos_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first && !pwrite && hit_pos |=>
      !pslverr && (prdata == {23'h0, $past(s_r.sel), $past(s_r.idx)}))
    else $error("position register read back wrong");

  err_no_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && pslverr |=>
      $stable(s_r.bank) && $stable(s_r.sel))
    else $error("refused write changed state");

  unaligned_err_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first && !aligned |=> pready && pslverr)
    else $error("unaligned access not refused");

  bank_wr_ok_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_first && hit_bank |=> pready && !pslverr)
    else $error("bank access refused");

  rd_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !acc_first |=> $stable(prdata))
    else $error("read data moved between answers");

  err_pulse_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    pslverr |-> pready)
    else $error("error flag without ready");

  ready_cause_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    pready |-> $past(acc_first))
    else $error("ready without an access");

  idx_wrap_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    frame_adv && !block_start && (s_r.idx == `STA_LAST_BIT) |=>
      s_r.idx == `STA_IDX_RST)
    else $error("frame position did not wrap");

  out_reset_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (tx_aux_bits == 8'h00) && (s_r.idx == `STA_IDX_RST) &&
      !pready && !pslverr)
    else $error("outputs not idle after reset");

  bank_wr_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && pwrite && hit_bank);

  bank_rd_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    acc_done && !pwrite && hit_bank);

  block_reg_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    lane_load && !s_r.sel ##[1:16] frame_adv);

  rx_frame_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    frame_adv && s_r.sel);

  idx_wrap_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    frame_adv && !block_start && (s_r.idx == `STA_LAST_BIT));
endmodule

// ---- hw/sta_defines.svh ----
// Register map, field positions, reset values and counts of the bank
// What this block does
// - Twelve 16-bit registers from index F6A0 hold left channel status bits and reset to zero.
// - Twelve 16-bit registers from index F6B0 hold right channel status bits and reset to zero.
// - Twelve 16-bit registers from index F6C0 hold left user data bits and reset to zero.
// - Twelve 16-bit registers from index F6D0 hold right user data bits and reset to zero.
// - Twelve 16-bit registers from index F6E0 hold left validity bits and reset to zero.
// - Twelve 16-bit registers from index F6F0 hold right validity bits and reset to zero.
// - Twelve 16-bit registers from index F700 hold left parity bits and reset to zero.
// - Twelve 16-bit registers from index F710 hold right parity bits and reset to zero.
// - Banked bits go to the encoder only while bit 0 of the origin select at F69F is zero.
// - With the origin select at one, the receiver's decoded bits are passed on instead.
`ifndef STA_DEFINES_SVH
`define STA_DEFINES_SVH

// Register indices; byte address is four times the index
`define STA_SEL_IDX 16'hF69F
`define STA_CS_L_IDX 16'hF6A0
`define STA_CS_R_IDX 16'hF6B0
`define STA_UD_L_IDX 16'hF6C0
`define STA_UD_R_IDX 16'hF6D0
`define STA_VB_L_IDX 16'hF6E0
`define STA_VB_R_IDX 16'hF6F0
`define STA_PB_L_IDX 16'hF700
`define STA_PB_R_IDX 16'hF710
`define STA_LAST_IDX 16'hF71B
`define STA_POS_IDX 16'hF720

// Layout and counts
`define STA_BANKS 8
`define STA_REGS 96
`define STA_WORDS 7'h0C
`define STA_STRIDE_SH 4
`define STA_LAST_BIT 8'hBF
`define STA_SEL_BIT 0
`define STA_ADDR_W 18

// Reset values
`define STA_BANK_RST 16'h0000
`define STA_SEL_RST 1'b0
`define STA_IDX_RST 8'h00

`endif

// ---- hw/sta_pkg.sv ----
// Types shared by the side-info bank modules
package sta_pkg;
`include "sta_defines.svh"

  typedef logic [`STA_ADDR_W-1:0] sta_addr_t;
  typedef logic [15:0] sta_word_t;

  typedef struct packed {
    sta_word_t [`STA_REGS-1:0] bank;
    logic sel;
    logic [7:0] idx;
    logic [7:0] aux;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sta_state_s;

  typedef struct packed {
    logic [191:0] shadow;
  } sta_lane_s;
endpackage

// ---- hw/sta_lane_if.sv ----
// Link between the register file and one bit lane
`timescale 1ns/1ps
interface sta_lane_if;
  logic load;
  logic [191:0] image;
  logic [7:0] idx;
  logic bit_o;
  modport bank (output load, output image, output idx, input bit_o);
  modport lane (input load, input image, input idx, output bit_o);
endinterface

// ---- hw/sta_lane.sv ----
// One bit lane: block shadow of a bank and bit selection
`timescale 1ns/1ps
module sta_lane (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bank side
  sta_lane_if.lane lif
);
  import sta_pkg::*;

  sta_lane_s s_r;
  sta_lane_s s_nxt;

  // Shadow taken at block start, so writes land on the next block
  always_comb begin
    s_nxt = s_r;
    if (lif.load) begin
      s_nxt.shadow = lif.image;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // First bit of a block comes straight from the fresh image
  assign lif.bit_o = lif.load ? lif.image[0] : s_r.shadow[lif.idx];

  shadow_load_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    lif.load |=> s_r.shadow == $past(lif.image))
    else $error("lane shadow not loaded at block start");
endmodule

// ---- verification/sta_enc_model.sv ----
// Encoder model: frame strobes, block starts, receiver bits
`timescale 1ns/1ps
module sta_enc_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bench control
  input wire logic run,
  input wire logic [3:0] gap,
  // Frame side of the bank
  output logic frame_adv,
  output logic block_start,
  output logic [7:0] rx_aux_bits
);
  logic [3:0] wait_r;
  logic [7:0] fidx_r;
  logic go;
  assign go = run && wait_r == 4'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 4'h0;
      fidx_r <= 8'h00;
      frame_adv <= 1'b0;
      block_start <= 1'b0;
      rx_aux_bits <= 8'h00;
    end else begin
      frame_adv <= go;
      // Top gap bit drops a block start, so the position must wrap alone
      block_start <= go && fidx_r == 8'h00 && !gap[3];
      if (go) begin
        wait_r <= gap;
        fidx_r <= (fidx_r == 8'hBF) ? 8'h00 : fidx_r + 8'h01;
        rx_aux_bits <= rx_aux_bits + 8'h5B;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule

// ---- verification/spdif_tx_aux_bit_bank_tb.sv ----
// Self-checking bench for the side-info register bank
`timescale 1ns/1ps
module spdif_tx_aux_bit_bank_tb;
  import sta_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, run;
  logic frame_adv, block_start, sel_o, chk, e, sel_m;
  sta_addr_t paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [7:0] rx_aux_bits, tx_aux_bits, ex, nidx, p;
  logic [3:0] gap;
  logic [1:0] lo;
  logic [191:0] img [8];
  logic [191:0] snap [8];
  logic [15:0] bad [4] = '{16'hF6AC, 16'hF69E, 16'hF71C, 16'hF6FF};
  int seed, failures, checks_done;
  sta_aux_bank u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_adv(frame_adv), .block_start(block_start),
    .rx_aux_bits(rx_aux_bits), .tx_aux_bits(tx_aux_bits),
    .side_info_origin_select(sel_o));
  sta_enc_model u_enc (.sys_clk(sys_clk), .rst(rst), .run(run),
    .gap(gap), .frame_adv(frame_adv), .block_start(block_start),
    .rx_aux_bits(rx_aux_bits));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] adr(input int b, input int w);
    return 16'(16'hF6A0 + 16 * b + w);
  endfunction
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] ix,
      input logic [31:0] wd);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, lo};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) begin
      failures++;
      $display("ERROR t=%0t pready %h exp %h", $time, pready, 1'b1);
    end
    q = prdata;
    e = pslverr;
    if (w && lo == 2'b00 && ix == 16'hF69F) sel_m <= wd[0];
    if (w && lo == 2'b00 && ix >= 16'hF6A0 && ix <= 16'hF71B &&
        ix[3:0] < 4'hC)
      img[3'(ix[8:4] - 5'h0A)][16 * ix[3:0] +: 16] <= wd[15:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Predict the encoder bits from the mirror
  always @(posedge sys_clk) begin
    if (rst) begin
      chk <= 1'b0;
      nidx <= 8'h00;
      for (int b = 0; b < 8; b++) snap[b] <= '0;
    end else begin
      chk <= frame_adv === 1'b1;
      if (frame_adv === 1'b1) begin
        p = block_start ? 8'h00 : nidx;
        for (int b = 0; b < 8; b++)
          ex[b] <= sel_m ? rx_aux_bits[b] :
            (block_start ? img[b][p] : snap[b][p]);
        nidx <= (p == 8'hBF) ? 8'h00 : p + 8'h01;
        if (block_start) snap <= img;
      end
    end
  end
  always @(negedge sys_clk)
    if (chk === 1'b1) ck({24'h0, tx_aux_bits}, {24'h0, ex});
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
  initial begin
    seed = 66;
    failures = 0;
    checks_done = 0;
    {rst, psel, penable, pwrite, run, sel_m} = 6'h20;
    lo = 2'b00;
    paddr = '0;
    pwdata = 32'h0;
    gap = 4'h0;
    for (int b = 0; b < 8; b++) img[b] = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int b = 0; b < 8; b++)
      for (int w = 0; w < 12; w++) begin
        apb(1'b0, adr(b, w), 32'h0);
        ck(q, 32'h0);
      end
    ck({31'h0, sel_o}, 32'h0);
    $display("test reset_values done");
    for (int b = 0; b < 8; b++)
      for (int w = 0; w < 12; w++) begin
        d = (w == 11) ? 32'hFFFFFFFF : $random(seed);
        apb(1'b1, adr(b, w), d);
      end
    foreach (bad[i]) apb(1'b1, bad[i], 32'hFFFF);
    for (int b = 0; b < 8; b++)
      for (int w = 0; w < 12; w++) begin
        apb(1'b0, adr(b, w), 32'h0);
        ck(q, {16'h0, img[b][16 * w +: 16]});
        ck({31'h0, e}, 32'h0);
      end
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0);
      ck({q[30:0], e}, 32'h1);
    end
    apb(1'b1, 16'hF69F, 32'hFFFE);
    apb(1'b0, 16'hF69F, 32'h0);
    ck(q, 32'h0);
    $display("test register_access done");
    run <= 1'b1;
    for (int i = 0; i < 90; i++) begin
      d = $random(seed);
      gap <= {d[20], 1'b0, d[3:2]};
      if (i == 30 || i == 60) apb(1'b1, 16'hF69F, {31'h0, i == 30});
      if (i == 31) ck({31'h0, sel_o}, 32'h1);
      apb(1'b1, adr(d[6:4], d[11:8] % 12), d);
      repeat (d[14:8]) @(posedge sys_clk);
    end
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    $display("test frame_stream done");
    apb(1'b0, 16'hF720, 32'h0);
    ck(q, {23'h0, sel_m, nidx});
    apb(1'b1, 16'hF720, 32'h1FF);
    ck({31'h0, e}, 32'h0);
    apb(1'b0, 16'hF720, 32'h0);
    ck(q, {23'h0, sel_m, nidx});
    lo = 2'b10;
    apb(1'b1, adr(0, 0), 32'h1234);
    ck({q[30:0], e}, 32'h1);
    lo = 2'b00;
    apb(1'b0, adr(0, 0), 32'h0);
    ck(q, {16'h0, img[0][15:0]});
    $display("test position_and_unaligned done");
    give_verdict();
  end
endmodule
